// [rtl/ttcu_top.sv]
// Three 16-bit timer/counters with an Avalon-MM register slave
//
// Summary of operation
// - Timer B overflow sets its flag
// - Timer A overflow sets its flag
// - Timer B counts only while run set
// - Timer A counts only while run set; split high byte runs on B's run bit
// - External interrupts A/B set their flags
// - Type B: 1 falling edge, 0 low level
// - Type A: 1 falling edge, 0 low level
// - Service entry clears flags, not run/type
// - Gate bits enable pin gating per timer
// - Select external events or internal clock
// - Timer B: 13, 16, 8-reload, stopped
// - Timer A: 13, 16, 8-reload, split
// - Live counts readable as byte pairs
// - Timer C clock is core/12 or /24
// - Interrupt D edge: 0 falling, 1 rising
// - Interrupt C edge: 0 falling, 1 rising
// - Timer C reload off, mode 0, 1
// - Compare bit picks compare mode 0/1
// - Timer C stopped, clock, edge, gated
// - Channels 1-3 capture on low write
// - Main channel: off, compare, capture
// - Timer mode ticks every 12 cycles
// - Counter mode counts falling pin edges
// - Reload on overflow or trigger fall
// - Gated timer C holds while input low
`timescale 1ns/100ps
`include "ttcu_params.svh"
module ttcu_top (
   input  wire logic        SYS_CLK_I,
   input  wire logic        NRST_I,
   input  wire logic [7:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [3:0]  AVS_BYTEENABLE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   output logic      [31:0] AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   input  wire logic        COUNT_IN_A_I,
   input  wire logic        COUNT_IN_B_I,
   input  wire logic        COUNT_IN_C_I,
   input  wire logic        RELOAD_TRIGGER_IN_I,
   input  wire logic        EXT_IRQ_A_N_I,
   input  wire logic        EXT_IRQ_B_N_I,
   input  wire logic        EXT_IRQ_C_I,
   input  wire logic        EXT_IRQ_D_I,
   input  wire logic [3:0]  SVC_ACK_I,
   output logic      [3:0]  IRQ_FLAGS_O,
   output logic             IRQ_C_EVENT_O,
   output logic             IRQ_D_EVENT_O,
   output logic             OVF_C_O,
   output logic             CMP_OUT_O
);
   // Register state
   ttcu_pkg::ttcu_abctl_t abctl_ff;
   ttcu_pkg::ttcu_abctl_t nxt_abctl;
   ttcu_pkg::ttcu_abcfg_t abcfg_ff;
   ttcu_pkg::ttcu_cctl_t  cctl_ff;
   ttcu_pkg::ttcu_cc_enable_cfg_t  cc_enable_cfg_ff;
   ttcu_pkg::ttcu_word_t  cnt_c_ff;
   ttcu_pkg::ttcu_word_t  nxt_cnt_c;
   ttcu_pkg::ttcu_word_t  crc_ff;
   ttcu_pkg::ttcu_word_t  nxt_crc;
   ttcu_pkg::ttcu_word_t  cap_ff [3];
   ttcu_pkg::ttcu_bus_t   bus_ff;
   logic [31:0]           rdata_ff;
   logic                  wait_ff;
   logic [3:0]            presc_ff;
   logic                  half_ff;
   logic                  cmp_ff;
   logic                  ovf_c_ff;
   logic                  irq_c_ff;
   logic                  irq_d_ff;

   // Bus decode
   wire        bus_req = AVS_READ_I | AVS_WRITE_I;
   wire        bus_acc = bus_ff == ttcu_pkg::TTCU_BUS_ACK;
   wire        wr_acc  = bus_acc & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
   wire [7:0]  wdata   = AVS_WRITEDATA_I[7:0];

   function automatic logic wr_at(input logic [7:0] adr);
      wr_at = wr_acc & (AVS_ADDRESS_I == adr);
   endfunction : wr_at

   wire        wr_abctl = wr_at(`TTCU_ADR_AB_CTL);
   wire        wr_abcfg = wr_at(`TTCU_ADR_AB_CFG);
   wire        wr_a_lo  = wr_at(`TTCU_ADR_CNT_A_LO);
   wire        wr_a_hi  = wr_at(`TTCU_ADR_CNT_A_HI);
   wire        wr_b_lo  = wr_at(`TTCU_ADR_CNT_B_LO);
   wire        wr_b_hi  = wr_at(`TTCU_ADR_CNT_B_HI);
   wire        wr_cc_enable_cfg  = wr_at(`TTCU_ADR_CC_EN);
   wire        wr_cctl  = wr_at(`TTCU_ADR_C_CTL);
   wire        wr_crc_l = wr_at(`TTCU_ADR_CRC_LO);
   wire        wr_crc_h = wr_at(`TTCU_ADR_CRC_HI);
   wire        wr_c_lo  = wr_at(`TTCU_ADR_CNT_C_LO);
   wire        wr_c_hi  = wr_at(`TTCU_ADR_CNT_C_HI);
   wire [2:0]  wr_cap_l = {wr_at(`TTCU_ADR_CAP3_LO), wr_at(`TTCU_ADR_CAP2_LO), wr_at(`TTCU_ADR_CAP1_LO)};
   wire [2:0]  wr_cap_h = {wr_at(`TTCU_ADR_CAP3_HI), wr_at(`TTCU_ADR_CAP2_HI), wr_at(`TTCU_ADR_CAP1_HI)};

   // Pin edges: 0 cnt A, 1 cnt B, 2 cnt C, 3 reload, 4 irq A, 5 irq B, 6 irq C, 7 irq D
   logic [7:0] fall;
   logic [7:0] rise;

   ttcu_edge u_edge (
      .clk_i  (SYS_CLK_I),
      .nrst_i (NRST_I),
      .sig_i  ({EXT_IRQ_D_I, EXT_IRQ_C_I, EXT_IRQ_B_N_I, EXT_IRQ_A_N_I,
                RELOAD_TRIGGER_IN_I, COUNT_IN_C_I, COUNT_IN_B_I, COUNT_IN_A_I}),
      .fall_o (fall),
      .rise_o (rise)
   );

   // Shared prescaler; timer C takes every tick or every second one
   wire tick12 = presc_ff == (`TTCU_DIV_AB - `TTCU_DIV_STEP);
   wire tick_c = tick12 & (~cctl_ff.third_prescale_sel | half_ff);

   // Timers A and B
   wire run_a  = abctl_ff.run_ctl_a & (~abcfg_ff.gate_ctl_a | EXT_IRQ_A_N_I);
   wire run_b  = abctl_ff.run_ctl_b & (~abcfg_ff.gate_ctl_b | EXT_IRQ_B_N_I);
   wire src_a  = abcfg_ff.count_sel_a ? fall[0] : tick12;
   wire src_b  = abcfg_ff.count_sel_b ? fall[1] : tick12;
   wire inc_a  = run_a & src_a;
   wire inc_ah = abctl_ff.run_ctl_b & tick12;
   wire inc_b  = run_b & src_b & (abcfg_ff.op_sel_b != ttcu_pkg::TTCU_SPLIT);
   logic [7:0] a_lo;
   logic [7:0] a_hi;
   logic [7:0] b_lo;
   logic [7:0] b_hi;
   logic       ovf_a;
   logic       ovf_ah;
   logic       ovf_b;

   ttcu_ab_core u_core_a (
      .clk_i    (SYS_CLK_I),
      .nrst_i   (NRST_I),
      .mode_i   (abcfg_ff.op_sel_a),
      .inc_lo_i (inc_a),
      .inc_hi_i (inc_ah),
      .wr_lo_i  (wr_a_lo),
      .wr_hi_i  (wr_a_hi),
      .wdata_i  (wdata),
      .lo_o     (a_lo),
      .hi_o     (a_hi),
      .ovf_o    (ovf_a),
      .ovf_hi_o (ovf_ah)
   );

   ttcu_ab_core u_core_b (
      .clk_i    (SYS_CLK_I),
      .nrst_i   (NRST_I),
      .mode_i   (abcfg_ff.op_sel_b),
      .inc_lo_i (inc_b),
      .inc_hi_i (1'b0),
      .wr_lo_i  (wr_b_lo),
      .wr_hi_i  (wr_b_hi),
      .wdata_i  (wdata),
      .lo_o     (b_lo),
      .hi_o     (b_hi),
      .ovf_o    (ovf_b),
      .ovf_hi_o ()
   );

   // Interrupt flag events
   wire set_ovf_a = ovf_a;
   wire set_ovf_b = ovf_b | ovf_ah;
   wire set_ext_a = abctl_ff.ext_irq_type_a ? fall[4] : ~EXT_IRQ_A_N_I;
   wire set_ext_b = abctl_ff.ext_irq_type_b ? fall[5] : ~EXT_IRQ_B_N_I;

   // A hardware set beats a clear from software or service entry
   function automatic logic flag_nxt(input logic set, input logic cur, input logic wbit, input logic ack);
      flag_nxt = set | (wr_abctl ? wbit : cur & ~ack);
   endfunction : flag_nxt

   always_comb begin
      nxt_abctl                = wr_abctl ? ttcu_pkg::ttcu_abctl_t'(wdata) : abctl_ff;
      nxt_abctl.ext_irq_flag_a = flag_nxt(set_ext_a, abctl_ff.ext_irq_flag_a, wdata[1], SVC_ACK_I[0]);
      nxt_abctl.ovf_flag_a     = flag_nxt(set_ovf_a, abctl_ff.ovf_flag_a, wdata[5], SVC_ACK_I[1]);
      nxt_abctl.ext_irq_flag_b = flag_nxt(set_ext_b, abctl_ff.ext_irq_flag_b, wdata[3], SVC_ACK_I[2]);
      nxt_abctl.ovf_flag_b     = flag_nxt(set_ovf_b, abctl_ff.ovf_flag_b, wdata[7], SVC_ACK_I[3]);
   end

   // Timer C
   wire c_full  = &cnt_c_ff;
   wire inc_c   = (cctl_ff.third_input_sel == ttcu_pkg::TTCU_CI_CLK) & tick_c |
                  (cctl_ff.third_input_sel == ttcu_pkg::TTCU_CI_EDGE) & fall[2] |
                  (cctl_ff.third_input_sel == ttcu_pkg::TTCU_CI_GATED) & tick_c & COUNT_IN_C_I;
   wire ovf_c   = inc_c & c_full;
   wire rld_on  = cctl_ff.third_reload_sel[1];
   wire rld_m1  = cctl_ff.third_reload_sel[0];
   wire rld_c   = rld_on & (rld_m1 ? fall[3] : ovf_c);
   wire cap_crc = cc_enable_cfg_ff.cc_cfg_main == ttcu_pkg::TTCU_CC_CAP;
   wire cmp_en  = cc_enable_cfg_ff.cc_cfg_main == ttcu_pkg::TTCU_CC_CMP;
   wire cmp_hit = cnt_c_ff == crc_ff;
   wire cmp_ge  = cnt_c_ff >= crc_ff;

   always_comb begin
      nxt_cnt_c = cnt_c_ff;
      if (rld_c) begin
         nxt_cnt_c = crc_ff;
      end else if (inc_c) begin
         nxt_cnt_c = cnt_c_ff + 16'h0001;
      end
      if (wr_c_lo) begin
         nxt_cnt_c.lo = wdata;
      end
      if (wr_c_hi) begin
         nxt_cnt_c.hi = wdata;
      end
   end

   always_comb begin
      nxt_crc = crc_ff;
      if (wr_crc_l) begin
         nxt_crc = cap_crc ? cnt_c_ff : {crc_ff.hi, wdata};
      end
      if (wr_crc_h) begin
         nxt_crc.hi = wdata;
      end
   end

   // Mode 0 follows the comparison; mode 1 latches on a hit until overflow
   wire nxt_cmp = ~cmp_en ? 1'b0 :
                  ~cctl_ff.third_compare_sel ? cmp_ge :
                  cmp_hit | (cmp_ff & ~ovf_c);

   // Read multiplexer
   function automatic logic [7:0] rd_mux(input logic [7:0] adr);
      case (adr)
         `TTCU_ADR_AB_CTL:   rd_mux = abctl_ff;
         `TTCU_ADR_AB_CFG:   rd_mux = abcfg_ff;
         `TTCU_ADR_CNT_A_LO: rd_mux = a_lo;
         `TTCU_ADR_CNT_A_HI: rd_mux = a_hi;
         `TTCU_ADR_CNT_B_LO: rd_mux = b_lo;
         `TTCU_ADR_CNT_B_HI: rd_mux = b_hi;
         `TTCU_ADR_CC_EN:    rd_mux = cc_enable_cfg_ff;
         `TTCU_ADR_CAP1_LO:  rd_mux = cap_ff[0].lo;
         `TTCU_ADR_CAP1_HI:  rd_mux = cap_ff[0].hi;
         `TTCU_ADR_CAP2_LO:  rd_mux = cap_ff[1].lo;
         `TTCU_ADR_CAP2_HI:  rd_mux = cap_ff[1].hi;
         `TTCU_ADR_CAP3_LO:  rd_mux = cap_ff[2].lo;
         `TTCU_ADR_CAP3_HI:  rd_mux = cap_ff[2].hi;
         `TTCU_ADR_C_CTL:    rd_mux = cctl_ff;
         `TTCU_ADR_CRC_LO:   rd_mux = crc_ff.lo;
         `TTCU_ADR_CRC_HI:   rd_mux = crc_ff.hi;
         `TTCU_ADR_CNT_C_LO: rd_mux = cnt_c_ff.lo;
         `TTCU_ADR_CNT_C_HI: rd_mux = cnt_c_ff.hi;
         default:            rd_mux = `TTCU_RST_REG;
      endcase
   endfunction : rd_mux

   wire [7:0] rd_byte = AVS_READ_I ? rd_mux(AVS_ADDRESS_I) : `TTCU_RST_REG;

   // Bus handshake: every request waits exactly one cycle
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         bus_ff   <= ttcu_pkg::TTCU_BUS_IDLE;
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         case (bus_ff)
            ttcu_pkg::TTCU_BUS_IDLE: begin
               if (bus_req) begin
                  bus_ff   <= ttcu_pkg::TTCU_BUS_ACK;
                  wait_ff  <= 1'b0;
                  rdata_ff <= {24'h00_0000, rd_byte};
               end
            end
            default: begin
               bus_ff  <= ttcu_pkg::TTCU_BUS_IDLE;
               wait_ff <= 1'b1;
            end
         endcase
      end
   end

   // Prescaler
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         presc_ff <= 4'h0;
         half_ff  <= 1'b0;
      end else begin
         presc_ff <= tick12 ? 4'h0 : presc_ff + `TTCU_DIV_STEP;
         half_ff  <= half_ff ^ tick12;
      end
   end

   // Control registers
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         abctl_ff <= `TTCU_RST_REG;
         abcfg_ff <= `TTCU_RST_REG;
         cctl_ff  <= `TTCU_RST_REG;
         cc_enable_cfg_ff  <= `TTCU_RST_REG;
      end else begin
         abctl_ff <= nxt_abctl;
         if (wr_abcfg) begin
            abcfg_ff <= wdata;
         end
         if (wr_cctl) begin
            cctl_ff <= wdata;
         end
         if (wr_cc_enable_cfg) begin
            cc_enable_cfg_ff <= wdata;
         end
      end
   end

   // Timer C, reload/compare register and capture channels
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         cnt_c_ff <= `TTCU_RST_WORD;
         crc_ff   <= `TTCU_RST_WORD;
         for (int i = 0; i < 3; i++) begin
            cap_ff[i] <= `TTCU_RST_WORD;
         end
      end else begin
         cnt_c_ff <= nxt_cnt_c;
         crc_ff   <= nxt_crc;
         for (int i = 0; i < 3; i++) begin
            if (wr_cap_l[i]) begin
               // Capture only on code 11; other codes store the byte
               if (cc_enable_cfg_ff[2*i+2 +: 2] == ttcu_pkg::TTCU_CC_CAP) begin
                  cap_ff[i] <= cnt_c_ff;
               end else begin
                  cap_ff[i].lo <= wdata;
               end
            end
            if (wr_cap_h[i]) begin
               cap_ff[i].hi <= wdata;
            end
         end
      end
   end

   // Registered event outputs
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         cmp_ff   <= 1'b0;
         ovf_c_ff <= 1'b0;
         irq_c_ff <= 1'b0;
         irq_d_ff <= 1'b0;
      end else begin
         cmp_ff   <= nxt_cmp;
         ovf_c_ff <= ovf_c;
         irq_c_ff <= cctl_ff.edge_sel_irq_c ? rise[6] : fall[6];
         irq_d_ff <= cctl_ff.edge_sel_irq_d ? rise[7] : fall[7];
      end
   end

   assign AVS_READDATA_O    = rdata_ff;
   assign AVS_WAITREQUEST_O = wait_ff;
   assign IRQ_FLAGS_O       = {abctl_ff.ovf_flag_b, abctl_ff.ext_irq_flag_b,
                               abctl_ff.ovf_flag_a, abctl_ff.ext_irq_flag_a};
   assign IRQ_C_EVENT_O     = irq_c_ff;
   assign IRQ_D_EVENT_O     = irq_d_ff;
   assign OVF_C_O           = ovf_c_ff;
   assign CMP_OUT_O         = cmp_ff;
endmodule : ttcu_top

// [rtl/ttcu_params.svh]
// Register offsets, reset values and clock divide counts of the timer/counter unit
`ifndef TTCU_PARAMS_SVH
`define TTCU_PARAMS_SVH

// Register indices; the Avalon word address equals the index
`define TTCU_ADR_AB_CTL    8'h88
`define TTCU_ADR_AB_CFG    8'h89
`define TTCU_ADR_CNT_A_LO  8'h8a
`define TTCU_ADR_CNT_B_LO  8'h8b
`define TTCU_ADR_CNT_A_HI  8'h8c
`define TTCU_ADR_CNT_B_HI  8'h8d
`define TTCU_ADR_CC_EN     8'hc1
`define TTCU_ADR_CAP1_LO   8'hc2
`define TTCU_ADR_CAP1_HI   8'hc3
`define TTCU_ADR_CAP2_LO   8'hc4
`define TTCU_ADR_CAP2_HI   8'hc5
`define TTCU_ADR_CAP3_LO   8'hc6
`define TTCU_ADR_CAP3_HI   8'hc7
`define TTCU_ADR_C_CTL     8'hc8
`define TTCU_ADR_CRC_LO    8'hca
`define TTCU_ADR_CRC_HI    8'hcb
`define TTCU_ADR_CNT_C_LO  8'hcc
`define TTCU_ADR_CNT_C_HI  8'hcd

// Reset values
`define TTCU_RST_REG       8'h00
`define TTCU_RST_WORD      16'h0000
`define TTCU_EDGE_IDLE     8'hff

// Core clock cycles per timer tick, and the prescaler count step
`define TTCU_DIV_AB        4'hc
`define TTCU_DIV_STEP      4'h1

`endif

// [rtl/ttcu_pkg.sv]
// Types shared by the timer/counter unit
package ttcu_pkg;

   typedef enum logic [1:0] {
      TTCU_M13   = 2'h0,
      TTCU_M16   = 2'h1,
      TTCU_M8R   = 2'h2,
      TTCU_SPLIT = 2'h3
   } ttcu_mode_t;

   typedef enum logic [1:0] {
      TTCU_CI_STOP  = 2'h0,
      TTCU_CI_CLK   = 2'h1,
      TTCU_CI_EDGE  = 2'h2,
      TTCU_CI_GATED = 2'h3
   } ttcu_cin_t;

   typedef enum logic [1:0] {
      TTCU_CC_OFF = 2'h0,
      TTCU_CC_RSV = 2'h1,
      TTCU_CC_CMP = 2'h2,
      TTCU_CC_CAP = 2'h3
   } ttcu_cc_t;

   typedef enum logic [1:0] {
      TTCU_BUS_IDLE = 2'h1,
      TTCU_BUS_ACK  = 2'h2
   } ttcu_bus_t;

   typedef struct packed {
      logic ovf_flag_b;
      logic run_ctl_b;
      logic ovf_flag_a;
      logic run_ctl_a;
      logic ext_irq_flag_b;
      logic ext_irq_type_b;
      logic ext_irq_flag_a;
      logic ext_irq_type_a;
   } ttcu_abctl_t;

   typedef struct packed {
      logic       gate_ctl_b;
      logic       count_sel_b;
      ttcu_mode_t op_sel_b;
      logic       gate_ctl_a;
      logic       count_sel_a;
      ttcu_mode_t op_sel_a;
   } ttcu_abcfg_t;

   typedef struct packed {
      logic       third_prescale_sel;
      logic       edge_sel_irq_d;
      logic       edge_sel_irq_c;
      logic [1:0] third_reload_sel;
      logic       third_compare_sel;
      ttcu_cin_t  third_input_sel;
   } ttcu_cctl_t;

   typedef struct packed {
      ttcu_cc_t cc_cfg_three;
      ttcu_cc_t cc_cfg_two;
      ttcu_cc_t cc_cfg_one;
      ttcu_cc_t cc_cfg_main;
   } ttcu_cc_enable_cfg_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } ttcu_word_t;

endpackage : ttcu_pkg

// [rtl/ttcu_edge.sv]
// Edge detector for the synchronous pin inputs
`timescale 1ns/100ps
`include "ttcu_params.svh"
module ttcu_edge (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic [7:0] sig_i,
   output logic      [7:0] fall_o,
   output logic      [7:0] rise_o
);
   logic [7:0] prev_ff;

   // Idle high so a pin held high through reset gives no edge
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         prev_ff <= `TTCU_EDGE_IDLE;
      end else begin
         prev_ff <= sig_i;
      end
   end

   assign fall_o = prev_ff & ~sig_i;
   assign rise_o = ~prev_ff & sig_i;
endmodule : ttcu_edge

// [rtl/ttcu_ab_core.sv]
// Count register pair of timer A or B with its four modes
`timescale 1ns/100ps
`include "ttcu_params.svh"
module ttcu_ab_core (
   input  wire logic                clk_i,
   input  wire logic                nrst_i,
   input  wire ttcu_pkg::ttcu_mode_t mode_i,
   input  wire logic                inc_lo_i,
   input  wire logic                inc_hi_i,
   input  wire logic                wr_lo_i,
   input  wire logic                wr_hi_i,
   input  wire logic [7:0]          wdata_i,
   output logic      [7:0]          lo_o,
   output logic      [7:0]          hi_o,
   output logic                     ovf_o,
   output logic                     ovf_hi_o
);
   logic [7:0] lo_ff;
   logic [7:0] hi_ff;
   logic [7:0] nxt_lo;
   logic [7:0] nxt_hi;
   wire        lo5_full = &lo_ff[4:0];
   wire        lo_full  = &lo_ff;
   wire        hi_full  = &hi_ff;

   always_comb begin
      nxt_lo   = lo_ff;
      nxt_hi   = hi_ff;
      ovf_o    = 1'b0;
      ovf_hi_o = 1'b0;
      case (mode_i)
         ttcu_pkg::TTCU_M13: begin
            // Upper three low bits are left untouched
            if (inc_lo_i) begin
               nxt_lo[4:0] = lo_ff[4:0] + 5'h01;
               if (lo5_full) begin
                  nxt_hi = hi_ff + 8'h01;
                  ovf_o  = hi_full;
               end
            end
         end
         ttcu_pkg::TTCU_M16: begin
            if (inc_lo_i) begin
               {nxt_hi, nxt_lo} = {hi_ff, lo_ff} + 16'h0001;
               ovf_o            = hi_full & lo_full;
            end
         end
         ttcu_pkg::TTCU_M8R: begin
            if (inc_lo_i) begin
               nxt_lo = lo_full ? hi_ff : lo_ff + 8'h01;
               ovf_o  = lo_full;
            end
         end
         default: begin
            if (inc_lo_i) begin
               nxt_lo = lo_ff + 8'h01;
               ovf_o  = lo_full;
            end
            if (inc_hi_i) begin
               nxt_hi   = hi_ff + 8'h01;
               ovf_hi_o = hi_full;
            end
         end
      endcase
      if (wr_lo_i) begin
         nxt_lo = wdata_i;
      end
      if (wr_hi_i) begin
         nxt_hi = wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         lo_ff <= `TTCU_RST_REG;
         hi_ff <= `TTCU_RST_REG;
      end else begin
         lo_ff <= nxt_lo;
         hi_ff <= nxt_hi;
      end
   end

   assign lo_o = lo_ff;
   assign hi_o = hi_ff;
endmodule : ttcu_ab_core

// [dv/ttcu_checker.sv]
// Assertions on the register bus and flag ports of the timer/counter unit
`timescale 1ns/100ps
module ttcu_checker (
   input  wire logic        SYS_CLK_I,
   input  wire logic        NRST_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_READDATA_O,
   input  wire logic        AVS_WAITREQUEST_O,
   input  wire logic        EXT_IRQ_A_N_I,
   input  wire logic        EXT_IRQ_B_N_I,
   input  wire logic [3:0]  SVC_ACK_I,
   input  wire logic [3:0]  IRQ_FLAGS_O,
   input  wire logic        OVF_C_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!NRST_I);
   // Pin held high long enough that no detected edge or level is still in flight
   sequence s_quiet_a;
      EXT_IRQ_A_N_I [*4];
   endsequence
   sequence s_quiet_b;
      EXT_IRQ_B_N_I [*4];
   endsequence
   a_req_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("request not answered in one cycle");
   a_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("waitrequest low too long");
   a_no_unasked: assert property ($fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I))
      else $error("answer without request");
   a_upper_zero: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_ext_a_set: assert property ($fell(EXT_IRQ_A_N_I) |-> ##[1:3] IRQ_FLAGS_O[0])
      else $error("flag A not set by pin");
   a_ext_b_set: assert property ($fell(EXT_IRQ_B_N_I) |-> ##[1:3] IRQ_FLAGS_O[2])
      else $error("flag B not set by pin");
   a_ack_a_clr: assert property (s_quiet_a ##0 SVC_ACK_I[0] |=> !IRQ_FLAGS_O[0])
      else $error("flag A not cleared on service");
   a_ack_b_clr: assert property (s_quiet_b ##0 SVC_ACK_I[2] |=> !IRQ_FLAGS_O[2])
      else $error("flag B not cleared on service");
   a_ovf_c_pulse: assert property (OVF_C_O |=> !OVF_C_O)
      else $error("overflow pulse too long");
endmodule : ttcu_checker

bind ttcu_top ttcu_checker u_chk (
   .SYS_CLK_I        (SYS_CLK_I),
   .NRST_I           (NRST_I),
   .AVS_READ_I       (AVS_READ_I),
   .AVS_WRITE_I      (AVS_WRITE_I),
   .AVS_READDATA_O   (AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .EXT_IRQ_A_N_I    (EXT_IRQ_A_N_I),
   .EXT_IRQ_B_N_I    (EXT_IRQ_B_N_I),
   .SVC_ACK_I        (SVC_ACK_I),
   .IRQ_FLAGS_O      (IRQ_FLAGS_O),
   .OVF_C_O          (OVF_C_O)
);

// [dv/ttcu_pin_model.sv]
// Pin-side model: count inputs, timer C gate and reload trigger
`timescale 1ns/100ps
module ttcu_pin_model (
   input  wire logic       clk_i,
   input  wire logic [2:0] req_i,
   input  wire logic       gate_low_i,
   output logic            cnt_a_o,
   output logic            cnt_b_o,
   output logic            cnt_c_o,
   output logic            trig_o
);
   logic [2:0] req_ff = 3'h0;
   logic [2:0] pin_ff = 3'h7;
   // Two low cycles per request, so each level is stable long enough to be seen
   // Plain process: the start values come from the declarations, as the model has no reset
   always @(posedge clk_i) begin
      req_ff <= req_i;
      pin_ff <= ~(req_i | req_ff);
   end
   assign cnt_a_o = pin_ff[0];
   assign cnt_b_o = pin_ff[1];
   assign cnt_c_o = pin_ff[2] & ~gate_low_i;
   assign trig_o  = 1'b1;
endmodule : ttcu_pin_model

// [dv/tb_top.sv]
// Self-checking bench for the three timer/counter unit
`timescale 1ns/100ps
module tb_top;
   logic        SYS_CLK_I = 1'b0;
   logic        NRST_I = 1'b0;
   logic [7:0]  AVS_ADDRESS_I = 8'h00;
   logic        AVS_READ_I = 1'b0;
   logic        AVS_WRITE_I = 1'b0;
   logic [31:0] AVS_WRITEDATA_I = 32'h0;
   logic        EXT_IRQ_A_N_I = 1'b1;
   logic        EXT_IRQ_B_N_I = 1'b1;
   logic [3:0]  SVC_ACK_I = 4'h0;
   logic [2:0]  pin_req = 3'h0;
   logic        gate_low = 1'b0;
   logic        cnt_a, cnt_b, cnt_c, trig, wreq, ovf_c, evt_c, evt_d, cmp;
   logic        irq_cd = 1'b1;
   logic [31:0] rdata;
   logic [3:0]  flags;
   logic [7:0]  q, q2;
   int          fail_count = 0;
   int          compares = 0;
   // Rows: address, write data, expected read back
   logic [23:0] rows [7] = '{24'h89a5a5, 24'hc1e4e4, 24'hc87c7c, 24'h8d1212, 24'h8a3434, 24'h905500, 24'h880505};

   ttcu_top dut (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
      .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_BYTEENABLE_I(4'h1),
      .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
      .COUNT_IN_A_I(cnt_a), .COUNT_IN_B_I(cnt_b), .COUNT_IN_C_I(cnt_c), .RELOAD_TRIGGER_IN_I(trig),
      .EXT_IRQ_A_N_I(EXT_IRQ_A_N_I), .EXT_IRQ_B_N_I(EXT_IRQ_B_N_I), .EXT_IRQ_C_I(irq_cd),
      .EXT_IRQ_D_I(irq_cd), .SVC_ACK_I(SVC_ACK_I), .IRQ_FLAGS_O(flags), .IRQ_C_EVENT_O(evt_c),
      .IRQ_D_EVENT_O(evt_d), .OVF_C_O(ovf_c), .CMP_OUT_O(cmp));
   ttcu_pin_model u_pins (.clk_i(SYS_CLK_I), .req_i(pin_req), .gate_low_i(gate_low),
      .cnt_a_o(cnt_a), .cnt_b_o(cnt_b), .cnt_c_o(cnt_c), .trig_o(trig));

   initial begin
      forever #50 SYS_CLK_I = ~SYS_CLK_I;
   end

   task automatic report_and_stop();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      compares++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h..%h", $time, got, lo, hi);
      end
   endtask : chk

   // Request held until waitrequest is sampled low, then released
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge SYS_CLK_I);
      AVS_ADDRESS_I <= a;
      AVS_WRITEDATA_I <= {24'h0, d};
      AVS_WRITE_I <= wr;
      AVS_READ_I <= !wr;
      do begin
         @(posedge SYS_CLK_I);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         fail_count++;
         report_and_stop();
      end
      r = rdata[7:0];
      AVS_WRITE_I <= 1'b0;
      AVS_READ_I <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic pulse(input int i);
      @(posedge SYS_CLK_I);
      pin_req[i] <= 1'b1;
      @(posedge SYS_CLK_I);
      pin_req[i] <= 1'b0;
      repeat (5) @(posedge SYS_CLK_I);
   endtask : pulse

   task automatic ack(input logic [3:0] m);
      @(posedge SYS_CLK_I);
      SVC_ACK_I <= m;
      @(posedge SYS_CLK_I);
      SVC_ACK_I <= 4'h0;
      repeat (2) @(posedge SYS_CLK_I);
   endtask : ack

   initial begin
      repeat (20000) @(posedge SYS_CLK_I);
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge SYS_CLK_I);
      NRST_I <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         bus(1'b0, rows[i][23:16], 8'h00, q);
         chk(q, rows[i][7:0], rows[i][7:0]);
      end
      NRST_I <= 1'b0;
      repeat (16) @(posedge SYS_CLK_I);
      NRST_I <= 1'b1;
      foreach (rows[i]) begin
         bus(1'b0, rows[i][23:16], 8'h00, q);
         chk(q, 8'h00, 8'h00);
      end
      wr(8'h89, 8'h01);
      wr(8'h8c, 8'hff);
      wr(8'h8a, 8'hff);
      wr(8'h88, 8'h10);
      repeat (40) @(posedge SYS_CLK_I);
      chk({7'h0, flags[1]}, 8'h01, 8'h01);
      wr(8'h8a, 8'h00);
      wr(8'h8c, 8'h00);
      repeat (120) @(posedge SYS_CLK_I);
      wr(8'h88, 8'h00);
      bus(1'b0, 8'h8a, 8'h00, q);
      chk(q, 8'h0a, 8'h0b);
      repeat (30) @(posedge SYS_CLK_I);
      bus(1'b0, 8'h8a, 8'h00, q2);
      chk(q2, q, q);
      wr(8'h89, 8'h50);
      wr(8'h8b, 8'hfe);
      wr(8'h8d, 8'hff);
      wr(8'h88, 8'h40);
      repeat (3) pulse(1);
      bus(1'b0, 8'h8b, 8'h00, q);
      chk(q, 8'h01, 8'h01);
      chk({7'h0, flags[3]}, 8'h01, 8'h01);
      ack(4'h8);
      chk({7'h0, flags[3]}, 8'h00, 8'h00);
      bus(1'b0, 8'h88, 8'h00, q);
      chk(q, 8'h40, 8'h40);
      wr(8'h88, 8'h00);
      EXT_IRQ_A_N_I <= 1'b0;
      repeat (3) @(posedge SYS_CLK_I);
      EXT_IRQ_A_N_I <= 1'b1;
      repeat (5) @(posedge SYS_CLK_I);
      chk({7'h0, flags[0]}, 8'h01, 8'h01);
      ack(4'h1);
      chk({7'h0, flags[0]}, 8'h00, 8'h00);
      wr(8'h88, 8'h04);
      EXT_IRQ_B_N_I <= 1'b0;
      repeat (6) @(posedge SYS_CLK_I);
      chk({7'h0, flags[2]}, 8'h01, 8'h01);
      ack(4'h4);
      chk({7'h0, flags[2]}, 8'h00, 8'h00);
      EXT_IRQ_B_N_I <= 1'b1;
      repeat (5) @(posedge SYS_CLK_I);
      ack(4'h4);
      for (int p = 0; p < 2; p++) begin
         wr(8'hcc, 8'h00);
         wr(8'hc8, p ? 8'h81 : 8'h01);
         repeat (240) @(posedge SYS_CLK_I);
         wr(8'hc8, 8'h00);
         bus(1'b0, 8'hcc, 8'h00, q);
         chk(q, p ? 8'h0a : 8'h14, p ? 8'h0b : 8'h15);
      end
      gate_low <= 1'b1;
      wr(8'hcc, 8'h00);
      wr(8'hc8, 8'h03);
      repeat (60) @(posedge SYS_CLK_I);
      wr(8'hc8, 8'h00);
      gate_low <= 1'b0;
      bus(1'b0, 8'hcc, 8'h00, q);
      chk(q, 8'h00, 8'h00);
      wr(8'hcd, 8'hff);
      wr(8'hcc, 8'hfe);
      wr(8'hc8, 8'h02);
      repeat (3) pulse(2);
      bus(1'b0, 8'hcc, 8'h00, q);
      chk(q, 8'h01, 8'h01);
      bus(1'b0, 8'hcd, 8'h00, q);
      chk(q, 8'h00, 8'h00);
      // One pin feeds C (falling) and D (rising): each event shows two edges after its pin change
      wr(8'hc8, 8'h40);
      irq_cd <= 1'b0;
      repeat (2) @(posedge SYS_CLK_I);
      chk({6'h0, evt_d, evt_c}, 8'h01, 8'h01);
      irq_cd <= 1'b1;
      repeat (2) @(posedge SYS_CLK_I);
      chk({6'h0, evt_d, evt_c}, 8'h02, 8'h02);
      wr(8'hc1, 8'h02);
      repeat (2) @(posedge SYS_CLK_I);
      chk({7'h0, cmp}, 8'h01, 8'h01);
      report_and_stop();
   end
endmodule : tb_top
